// ==== logic/ebrac_regs.vh ====
`ifndef EBRAC_REGS_VH
`define EBRAC_REGS_VH

// Word widths of the two memories.
`define EBRAC_INSTR_W       14
`define EBRAC_DATA_W        8

// Core register locations, repeated in every bank (low seven address bits).
`define EBRAC_ADDR_INDF     7'h00
`define EBRAC_ADDR_PCL      7'h02
`define EBRAC_ADDR_STATUS   7'h03
`define EBRAC_ADDR_FSR      7'h04
`define EBRAC_ADDR_PCLATH   7'h0A

// Status register bit positions.
`define EBRAC_ST_CARRY      0
`define EBRAC_ST_NIBBLE     1
`define EBRAC_ST_ZERO       2
`define EBRAC_ST_PD         3
`define EBRAC_ST_TO         4
`define EBRAC_ST_RP0        5
`define EBRAC_ST_RP1        6
`define EBRAC_ST_IRP        7

// Reset values.
`define EBRAC_RST_STATUS    8'h18
`define EBRAC_RST_FSR       8'h00
`define EBRAC_RST_PCLATH    8'h00
`define EBRAC_RST_ACC       8'h00

// Arithmetic unit operation codes.
`define EBRAC_OP_ADD        4'h0
`define EBRAC_OP_SUB        4'h1
`define EBRAC_OP_AND        4'h2
`define EBRAC_OP_IOR        4'h3
`define EBRAC_OP_XOR        4'h4
`define EBRAC_OP_COM        4'h5
`define EBRAC_OP_INC        4'h6
`define EBRAC_OP_DEC        4'h7
`define EBRAC_OP_RL         4'h8
`define EBRAC_OP_RR         4'h9
`define EBRAC_OP_SWAP       4'hA
`define EBRAC_OP_PASS       4'hB
`define EBRAC_OP_CLR        4'hC
`define EBRAC_OP_BCLR       4'hD
`define EBRAC_OP_BSET       4'hE

// Second operand source select.
`define EBRAC_SRC_FILE      2'h0
`define EBRAC_SRC_LIT       2'h1
`define EBRAC_SRC_ACC       2'h2

// Timing: clock period in ns, then clock cycles of plain instructions and pipeline-refilling branches.
`define EBRAC_CLK_PERIOD_NS 8
`define EBRAC_INSTR_CYCLES  1
`define EBRAC_BRANCH_CYCLES 2

`endif

// ==== logic/ebrac_alu.v ====
`timescale 1ns/1ps
`include "ebrac_regs.vh"

module ebrac_alu (
  // Operation select and operands.
  input  wire [3:0] op,
  input  wire [7:0] acc,
  input  wire [7:0] opnd,
  input  wire       cin,
  input  wire [2:0] bsel,
  // Result and flags.
  output reg  [7:0] res,
  output reg        c_out,
  output reg        nibble_borrow_bit,
  output wire       z_out
);

  reg [8:0] sum;
  reg [4:0] nib;

  // Eight-bit two's-complement datapath; subtraction adds the inverted accumulator plus one,
  // so carry and nibble carry read high when no borrow occurred.
  always @* begin
    res               = opnd;
    c_out             = cin;
    nibble_borrow_bit = 1'b0;
    sum               = 9'h000;
    nib               = 5'h00;
    case (op)
      `EBRAC_OP_ADD: begin
        sum               = {1'b0, opnd} + {1'b0, acc};
        nib               = {1'b0, opnd[3:0]} + {1'b0, acc[3:0]};
        res               = sum[7:0];
        c_out             = sum[8];
        nibble_borrow_bit = nib[4];
      end
      `EBRAC_OP_SUB: begin
        sum               = {1'b0, opnd} + {1'b0, ~acc} + 9'h001;
        nib               = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
        res               = sum[7:0];
        c_out             = sum[8];
        nibble_borrow_bit = nib[4];
      end
      `EBRAC_OP_AND:  res = opnd & acc;
      `EBRAC_OP_IOR:  res = opnd | acc;
      `EBRAC_OP_XOR:  res = opnd ^ acc;
      `EBRAC_OP_COM:  res = ~opnd;
      `EBRAC_OP_INC:  res = opnd + 8'h01;
      `EBRAC_OP_DEC:  res = opnd - 8'h01;
      `EBRAC_OP_RL: begin
        res   = {opnd[6:0], cin};
        c_out = opnd[7];
      end
      `EBRAC_OP_RR: begin
        res   = {cin, opnd[7:1]};
        c_out = opnd[0];
      end
      `EBRAC_OP_SWAP: res = {opnd[3:0], opnd[7:4]};
      `EBRAC_OP_CLR:  res = 8'h00;
      `EBRAC_OP_BCLR: res = opnd & ~(8'h01 << bsel);
      `EBRAC_OP_BSET: res = opnd | (8'h01 << bsel);
      default:        res = opnd;
    endcase
  end

  // Zero reflects the full eight-bit result.
  assign z_out = (res == 8'h00);

endmodule

// ==== logic/ebrac_core.v ====
// Behaviour
// - Instructions are fetched on a program bus separate from the data bus, both active together.
// - Every instruction is one 14-bit word.
// - One whole 14-bit instruction word is taken from program memory every instruction cycle.
// - Fetch of the next instruction overlaps execution of the current one in two stages.
// - All 35 instructions take one cycle, except branches which refill the pipeline.
// - The arithmetic unit is 8 bits wide and adds, subtracts, shifts and does logic.
// - Arithmetic treats operands and results as two's complement unless stated otherwise.
// - Two-operand instructions use the accumulator and a file register or an immediate.
// - Single-operand instructions use the accumulator or a file register.
// - The accumulator is an 8-bit register with no data memory address.
// - Instructions update carry, nibble carry and zero in the status register as defined.
// - In subtraction carry is an active-low borrow and nibble carry an active-low nibble borrow.
// - All special registers, the program counter included, sit in the data address space.
// - The register file is reached by direct and by indirect addressing.
// - Every operation works on every register in every addressing mode.
`timescale 1ns/1ps
`include "ebrac_regs.vh"

module ebrac_core #(
  parameter PC_W   = 13, // Program counter width, at most 16.
  parameter STK_AW = 3   // Call stack index width.
) (
  // Clock and reset.
  input  wire                      clk,
  input  wire                      rst,
  // Program memory bus.
  output wire [PC_W-1:0]           pm_addr,
  input  wire [`EBRAC_INSTR_W-1:0] pm_data,
  // Data memory bus.
  output wire [8:0]                dm_addr,
  input  wire [`EBRAC_DATA_W-1:0]  dm_rdata,
  output wire [`EBRAC_DATA_W-1:0]  dm_wdata,
  output wire                      dm_we,
  // Observation of core state.
  output wire [`EBRAC_DATA_W-1:0]  acc_q,
  output wire [`EBRAC_DATA_W-1:0]  status_q,
  output wire                      exec_valid
);

  localparam STK_D = 1 << STK_AW;

  // Effective data address: location zero redirects through the pointer register.
  function [8:0] eff_addr;
    input [6:0] f;
    input [7:0] st;
    input [7:0] ptr;
    begin
      if (f == `EBRAC_ADDR_INDF)
        eff_addr = {st[`EBRAC_ST_IRP], ptr};
      else
        eff_addr = {st[`EBRAC_ST_RP1], st[`EBRAC_ST_RP0], f};
    end
  endfunction

  // True when an address lands on a core register held inside this block.
  function core_hit;
    input [8:0] a;
    begin
      core_hit = (a[6:0] == `EBRAC_ADDR_INDF) || (a[6:0] == `EBRAC_ADDR_PCL) ||
                 (a[6:0] == `EBRAC_ADDR_STATUS) || (a[6:0] == `EBRAC_ADDR_FSR) ||
                 (a[6:0] == `EBRAC_ADDR_PCLATH);
    end
  endfunction

  // Pipeline and architectural state.
  reg  [PC_W-1:0]           pc_r;
  reg  [`EBRAC_INSTR_W-1:0] ir_r;
  reg                       ir_valid_r;
  reg  [7:0]                acc_r;
  reg  [7:0]                status_r;
  reg  [7:0]                fsr_r;
  reg  [7:0]                pclath_r;
  reg  [PC_W-1:0]           stk_r [0:STK_D-1];
  reg  [STK_AW-1:0]         sp_r;

  // Decode results.
  reg  [3:0]                alu_op;
  reg  [1:0]                src_sel;
  reg                       wr_acc;
  reg                       wr_file;
  reg                       upd_z;
  reg                       upd_c;
  reg                       upd_nb;
  reg                       skip_z;
  reg                       btst;
  reg                       btst_set;
  reg                       do_goto;
  reg                       do_call;
  reg                       do_ret;

  // Datapath nets.
  wire [8:0]                addr;
  wire                      hit;
  reg  [7:0]                file_val;
  reg  [7:0]                opnd;
  wire [7:0]                alu_res;
  wire                      alu_c;
  wire                      alu_nb;
  wire                      alu_z;
  reg  [7:0]                status_nxt;
  wire                      ex;
  wire                      pcl_wr;
  wire                      do_skip;
  wire                      do_jump;
  reg  [PC_W-1:0]           jump_tgt;
  wire [15:0]               goto_full;
  wire [15:0]               pcl_full;
  wire [PC_W-1:0]           pc_inc;
  wire [STK_AW-1:0]         sp_dec;

  integer i;

  assign ex     = ir_valid_r;
  assign pc_inc = pc_r + {{(PC_W-1){1'b0}}, 1'b1};
  assign sp_dec = sp_r - {{(STK_AW-1){1'b0}}, 1'b1};

  // Direct or indirect operand address, decoded the same way for every register.
  assign addr = eff_addr(ir_r[6:0], status_r, fsr_r);
  assign hit  = core_hit(addr);

  // Instruction decode; every instruction is one 14-bit word.
  always @* begin
    alu_op   = `EBRAC_OP_PASS;
    src_sel  = `EBRAC_SRC_FILE;
    wr_acc   = 1'b0;
    wr_file  = 1'b0;
    upd_z    = 1'b0;
    upd_c    = 1'b0;
    upd_nb   = 1'b0;
    skip_z   = 1'b0;
    btst     = 1'b0;
    btst_set = 1'b0;
    do_goto  = 1'b0;
    do_call  = 1'b0;
    do_ret   = 1'b0;
    case (ir_r[13:12])
      2'h0: begin
        // Byte operations: bit 7 chooses the file register or the accumulator as destination.
        wr_file = ir_r[7];
        wr_acc  = ~ir_r[7];
        case (ir_r[11:8])
          4'h0: begin
            wr_acc  = 1'b0;
            src_sel = `EBRAC_SRC_ACC;
            if (!ir_r[7])
              wr_file = 1'b0;
            do_ret = ~ir_r[7] & ((ir_r[6:0] == 7'h08) | (ir_r[6:0] == 7'h09));
          end
          4'h1: begin
            alu_op = `EBRAC_OP_CLR;
            upd_z  = 1'b1;
          end
          4'h2: begin
            alu_op = `EBRAC_OP_SUB;
            upd_z  = 1'b1;
            upd_c  = 1'b1;
            upd_nb = 1'b1;
          end
          4'h3: begin
            alu_op = `EBRAC_OP_DEC;
            upd_z  = 1'b1;
          end
          4'h4: begin
            alu_op = `EBRAC_OP_IOR;
            upd_z  = 1'b1;
          end
          4'h5: begin
            alu_op = `EBRAC_OP_AND;
            upd_z  = 1'b1;
          end
          4'h6: begin
            alu_op = `EBRAC_OP_XOR;
            upd_z  = 1'b1;
          end
          4'h7: begin
            alu_op = `EBRAC_OP_ADD;
            upd_z  = 1'b1;
            upd_c  = 1'b1;
            upd_nb = 1'b1;
          end
          4'h8: upd_z = 1'b1;
          4'h9: begin
            alu_op = `EBRAC_OP_COM;
            upd_z  = 1'b1;
          end
          4'hA: begin
            alu_op = `EBRAC_OP_INC;
            upd_z  = 1'b1;
          end
          4'hB: begin
            alu_op = `EBRAC_OP_DEC;
            skip_z = 1'b1;
          end
          4'hC: begin
            alu_op = `EBRAC_OP_RR;
            upd_c  = 1'b1;
          end
          4'hD: begin
            alu_op = `EBRAC_OP_RL;
            upd_c  = 1'b1;
          end
          4'hE: alu_op = `EBRAC_OP_SWAP;
          default: begin
            alu_op = `EBRAC_OP_INC;
            skip_z = 1'b1;
          end
        endcase
      end
      2'h1: begin
        // Bit clear, bit set and the two bit tests.
        case (ir_r[11:10])
          2'h0: begin
            alu_op  = `EBRAC_OP_BCLR;
            wr_file = 1'b1;
          end
          2'h1: begin
            alu_op  = `EBRAC_OP_BSET;
            wr_file = 1'b1;
          end
          2'h2: btst = 1'b1;
          default: begin
            btst     = 1'b1;
            btst_set = 1'b1;
          end
        endcase
      end
      2'h2: begin
        do_goto = ir_r[11];
        do_call = ~ir_r[11];
      end
      default: begin
        // Literal operations against the accumulator.
        src_sel = `EBRAC_SRC_LIT;
        wr_acc  = 1'b1;
        case (ir_r[11:8])
          4'h4, 4'h5, 4'h6, 4'h7: do_ret = 1'b1;
          4'h8: begin
            alu_op = `EBRAC_OP_IOR;
            upd_z  = 1'b1;
          end
          4'h9: begin
            alu_op = `EBRAC_OP_AND;
            upd_z  = 1'b1;
          end
          4'hA: begin
            alu_op = `EBRAC_OP_XOR;
            upd_z  = 1'b1;
          end
          4'hB: wr_acc = 1'b0;
          4'hC, 4'hD: begin
            alu_op = `EBRAC_OP_SUB;
            upd_z  = 1'b1;
            upd_c  = 1'b1;
            upd_nb = 1'b1;
          end
          4'hE, 4'hF: begin
            alu_op = `EBRAC_OP_ADD;
            upd_z  = 1'b1;
            upd_c  = 1'b1;
            upd_nb = 1'b1;
          end
          default: alu_op = `EBRAC_OP_PASS;
        endcase
      end
    endcase
  end

  // File read: core registers inside, everything else from data memory; the accumulator
  // has no address and never appears here.
  always @* begin
    file_val = dm_rdata;
    if (hit) begin
      case (addr[6:0])
        `EBRAC_ADDR_PCL:    file_val = pc_r[7:0];
        `EBRAC_ADDR_STATUS: file_val = status_r;
        `EBRAC_ADDR_FSR:    file_val = fsr_r;
        `EBRAC_ADDR_PCLATH: file_val = pclath_r;
        default:            file_val = 8'h00;
      endcase
    end
  end

  // Second operand: file register, immediate or the accumulator itself.
  always @* begin
    case (src_sel)
      `EBRAC_SRC_LIT: opnd = ir_r[7:0];
      `EBRAC_SRC_ACC: opnd = acc_r;
      default:        opnd = file_val;
    endcase
  end

  ebrac_alu u_alu (
    .op                (alu_op),
    .acc               (acc_r),
    .opnd              (opnd),
    .cin               (status_r[`EBRAC_ST_CARRY]),
    .bsel              (ir_r[9:7]),
    .res               (alu_res),
    .c_out             (alu_c),
    .nibble_borrow_bit (alu_nb),
    .z_out             (alu_z)
  );

  // Status: a direct write lands first, then the flags of the operation win.
  always @* begin
    status_nxt = status_r;
    if (ex && wr_file && hit && addr[6:0] == `EBRAC_ADDR_STATUS)
      status_nxt = {alu_res[7:5], status_r[4:3], alu_res[2:0]};
    if (ex && upd_z)
      status_nxt[`EBRAC_ST_ZERO] = alu_z;
    if (ex && upd_c)
      status_nxt[`EBRAC_ST_CARRY] = alu_c;
    if (ex && upd_nb)
      status_nxt[`EBRAC_ST_NIBBLE] = alu_nb;
  end

  // Change of flow: jumps, returns, program counter writes and skips.
  assign goto_full = {pclath_r[7:3], ir_r[10:0]};
  assign pcl_full  = {pclath_r, alu_res};
  assign pcl_wr    = ex & wr_file & hit & (addr[6:0] == `EBRAC_ADDR_PCL);
  assign do_skip   = ex & ((skip_z & alu_z) | (btst & (file_val[ir_r[9:7]] == btst_set)));
  assign do_jump   = ex & (do_goto | do_call | do_ret | pcl_wr);

  always @* begin
    if (do_ret)
      jump_tgt = stk_r[sp_dec];
    else if (pcl_wr)
      jump_tgt = pcl_full[PC_W-1:0];
    else
      jump_tgt = goto_full[PC_W-1:0];
  end

  // Fetch stage runs every cycle alongside execute; a branch or skip voids the fetched word.
  always @(posedge clk) begin
    if (rst) begin
      pc_r       <= {PC_W{1'b0}};
      ir_r       <= {`EBRAC_INSTR_W{1'b0}};
      ir_valid_r <= 1'b0;
      acc_r      <= `EBRAC_RST_ACC;
      status_r   <= `EBRAC_RST_STATUS;
      fsr_r      <= `EBRAC_RST_FSR;
      pclath_r   <= `EBRAC_RST_PCLATH;
      sp_r       <= {STK_AW{1'b0}};
      for (i = 0; i < STK_D; i = i + 1)
        stk_r[i] <= {PC_W{1'b0}};
    end else begin
      ir_r     <= pm_data;
      status_r <= status_nxt;
      if (do_jump) begin
        pc_r       <= jump_tgt;
        ir_valid_r <= 1'b0;
      end else begin
        pc_r       <= pc_inc;
        ir_valid_r <= ~do_skip;
      end
      if (ex && wr_acc)
        acc_r <= alu_res;
      if (ex && wr_file && hit && addr[6:0] == `EBRAC_ADDR_FSR)
        fsr_r <= alu_res;
      if (ex && wr_file && hit && addr[6:0] == `EBRAC_ADDR_PCLATH)
        pclath_r <= alu_res;
      if (ex && do_call) begin
        stk_r[sp_r] <= pc_r;
        sp_r        <= sp_r + {{(STK_AW-1){1'b0}}, 1'b1};
      end else if (ex && do_ret) begin
        sp_r <= sp_dec;
      end
    end
  end

  // Program and data buses are separate ports and work in the same cycle.
  assign pm_addr    = pc_r;
  assign dm_addr    = addr;
  assign dm_wdata   = alu_res;
  assign dm_we      = ex & wr_file & ~hit;
  assign acc_q      = acc_r;
  assign status_q   = status_r;
  assign exec_valid = ir_valid_r;

endmodule

// ==== bench/ebrac_core_sva.sv ====
`timescale 1ns/1ps
`include "ebrac_regs.vh"

module ebrac_core_sva #(
  parameter int PC_W = 13
) (
  // Clock and reset.
  input wire logic                      clk,
  input wire logic                      rst,
  // Program and data buses.
  input wire logic [PC_W-1:0]           pm_addr,
  input wire logic [`EBRAC_INSTR_W-1:0] pm_data,
  input wire logic [8:0]                dm_addr,
  input wire logic [`EBRAC_DATA_W-1:0]  dm_rdata,
  input wire logic [`EBRAC_DATA_W-1:0]  dm_wdata,
  input wire logic                      dm_we,
  // Core state.
  input wire logic [`EBRAC_DATA_W-1:0]  acc_q,
  input wire logic [`EBRAC_DATA_W-1:0]  status_q,
  input wire logic                      exec_valid
);
  // All checks share the one clock and are quiet while reset is applied.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_reset_state;
    $fell(rst) |-> pm_addr == '0 && !exec_valid && acc_q == `EBRAC_RST_ACC
      && status_q == `EBRAC_RST_STATUS;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

  property p_first_fetch;
    $fell(rst) |=> exec_valid && pm_addr == 1;
  endproperty
  a_first_fetch: assert property (p_first_fetch) else $error("first fetch late");

  property p_seq_fetch;
    exec_valid && $past(exec_valid) |-> pm_addr == $past(pm_addr) + 1'b1;
  endproperty
  a_seq_fetch: assert property (p_seq_fetch) else $error("fetch not sequential");

  property p_void_one;
    !exec_valid |=> exec_valid;
  endproperty
  a_void_one: assert property (p_void_one) else $error("void longer than one");

  property p_void_no_store;
    !exec_valid |-> !dm_we;
  endproperty
  a_void_no_store: assert property (p_void_no_store) else $error("store in void");

  property p_void_no_effect;
    !$past(exec_valid) && !$past(rst) |-> $stable(acc_q) && $stable(status_q);
  endproperty
  a_void_no_effect: assert property (p_void_no_effect) else $error("void changed state");

  property p_core_inside;
    dm_we |-> !(dm_addr[6:0] inside {`EBRAC_ADDR_INDF, `EBRAC_ADDR_PCL, `EBRAC_ADDR_STATUS,
      `EBRAC_ADDR_FSR, `EBRAC_ADDR_PCLATH});
  endproperty
  a_core_inside: assert property (p_core_inside) else $error("core register leaked");

  property p_status_fixed;
    !$past(rst) |-> $stable(status_q[4:3]);
  endproperty
  a_status_fixed: assert property (p_status_fixed) else $error("power bits moved");
endmodule

bind ebrac_core ebrac_core_sva #(.PC_W(PC_W)) u_sva (
  .clk(clk), .rst(rst), .pm_addr(pm_addr), .pm_data(pm_data), .dm_addr(dm_addr),
  .dm_rdata(dm_rdata), .dm_wdata(dm_wdata), .dm_we(dm_we), .acc_q(acc_q),
  .status_q(status_q), .exec_valid(exec_valid)
);

// ==== bench/ebrac_mem_model.sv ====
`timescale 1ns/1ps
`include "ebrac_regs.vh"

module ebrac_mem_model #(
  parameter int PC_W = 13
) (
  // Clock.
  input  wire logic                      clk,
  // Program memory side.
  input  wire logic [PC_W-1:0]           pm_addr,
  output logic      [`EBRAC_INSTR_W-1:0] pm_data,
  // Data memory side.
  input  wire logic [8:0]                dm_addr,
  output logic      [`EBRAC_DATA_W-1:0]  dm_rdata,
  input  wire logic [`EBRAC_DATA_W-1:0]  dm_wdata,
  input  wire logic                      dm_we,
  // Program loading.
  input  wire logic                      ld_stb,
  input  wire logic [PC_W-1:0]           ld_addr,
  input  wire logic [`EBRAC_INSTR_W-1:0] ld_word
);
  logic [`EBRAC_INSTR_W-1:0] pm_mem [0:(1<<PC_W)-1];
  logic [`EBRAC_DATA_W-1:0]  dm_mem [0:511];

  // Unloaded words read as no-operation so that prefetch past the end is harmless.
  initial begin
    for (int i = 0; i < (1 << PC_W); i++) pm_mem[i] = '0;
  end

  // A whole instruction word every cycle on its own bus, read with no wait.
  assign pm_data  = pm_mem[pm_addr];
  // The data bus is independent of the program bus and answers in the same cycle.
  assign dm_rdata = dm_mem[dm_addr];

  // Program words arrive through the loading strobe.
  always @(posedge ld_stb) begin
    pm_mem[ld_addr] <= ld_word;
  end

  // Stores land at the edge where the write enable is high.
  always @(posedge clk) begin
    if (dm_we === 1'b1) dm_mem[dm_addr] <= dm_wdata;
  end
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`include "ebrac_regs.vh"

module tb;
  localparam int PC_W = 13;
  // Design pins.
  logic            clk;
  logic            rst;
  logic [PC_W-1:0] pm_addr;
  logic [13:0]     pm_data;
  logic [8:0]      dm_addr;
  logic [7:0]      dm_rdata;
  logic [7:0]      dm_wdata;
  logic            dm_we;
  logic [7:0]      acc_q;
  logic [7:0]      status_q;
  logic            exec_valid;
  // Program loading and bookkeeping.
  logic            ld_stb;
  logic [PC_W-1:0] ld_addr;
  logic [13:0]     ld_word;
  logic [13:0]     prog [$];
  logic [16:0]     exp_q [$];
  logic [7:0]      w_exp;
  logic [3:0]      ops [12] = '{4'h7, 4'h2, 4'h5, 4'h4, 4'h6, 4'h9, 4'hA, 4'h3, 4'hC, 4'hD,
                                4'hE, 4'h8};
  integer          failures;
  integer          compares;
  integer          seed;

  ebrac_core #(.PC_W(PC_W), .STK_AW(3)) dut (
    .clk(clk), .rst(rst), .pm_addr(pm_addr), .pm_data(pm_data), .dm_addr(dm_addr),
    .dm_rdata(dm_rdata), .dm_wdata(dm_wdata), .dm_we(dm_we), .acc_q(acc_q),
    .status_q(status_q), .exec_valid(exec_valid)
  );

  ebrac_mem_model #(.PC_W(PC_W)) mem (
    .clk(clk), .pm_addr(pm_addr), .pm_data(pm_data), .dm_addr(dm_addr),
    .dm_rdata(dm_rdata), .dm_wdata(dm_wdata), .dm_we(dm_we), .ld_stb(ld_stb),
    .ld_addr(ld_addr), .ld_word(ld_word)
  );

  // Free-running clock of 8 ns.
  initial clk = 1'b0;
  always #4 clk = ~clk;

  task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic emit(input logic [13:0] w);
    prog.push_back(w);
  endtask

  task automatic movlw(input logic [7:0] k);
    emit({6'b110000, k});
    w_exp = k;
  endtask

  // Store the accumulator and, when asked, note the store the bus must show.
  task automatic movwf(input logic [6:0] f, input logic [1:0] bank, input logic keep);
    emit({7'b0000001, f});
    if (keep) exp_q.push_back({bank, f, w_exp});
  endtask

  function automatic logic [7:0] ref_op(input logic [3:0] opc, input logic [7:0] f,
                                        input logic [7:0] w);
    case (opc)
      4'h7: ref_op = f + w;
      4'h2: ref_op = f - w;
      4'h5: ref_op = f & w;
      4'h4: ref_op = f | w;
      4'h6: ref_op = f ^ w;
      4'h9: ref_op = ~f;
      4'hA: ref_op = f + 8'h01;
      4'h3: ref_op = f - 8'h01;
      4'hC: ref_op = {1'b0, f[7:1]};
      4'hD: ref_op = {f[6:0], 1'b0};
      4'hE: ref_op = {f[3:0], f[7:4]};
      default: ref_op = f;
    endcase
  endfunction

  // Literal add or subtract, then the result and a copy of the flags are stored.
  task automatic flag_case(input logic sub, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic       c;
    logic       nb;
    movlw(a);
    emit(sub ? {6'b111100, b} : {6'b111110, b});
    s  = sub ? {1'b0, b} - {1'b0, a} : {1'b0, a} + {1'b0, b};
    c  = sub ? (b >= a) : s[8];
    nb = sub ? (b[3:0] >= a[3:0]) : ({1'b0, a[3:0]} + {1'b0, b[3:0]} > 5'h0F);
    w_exp = s[7:0];
    movwf(7'h20, 2'b00, 1'b1);
    emit(14'h0803);
    w_exp = 8'h18 | {5'h00, s[7:0] == 8'h00, nb, c};
    movwf(7'h21, 2'b00, 1'b1);
  endtask

  // Every store seen on the data bus is matched against the oldest note.
  always @(posedge clk) begin
    if (rst === 1'b0 && dm_we === 1'b1) begin
      check("store", {dm_addr, dm_wdata}, exp_q.size() ? exp_q.pop_front() : 17'bx);
    end
  end

  // Watchdog for a hung run.
  initial begin
    #(8 * 4000);
    failures++;
    $display("ERROR watchdog expected done seen timeout");
    finish_test;
  end

  initial begin
    logic [7:0] v;
    logic [7:0] w;
    seed = 42;
    failures = 0;
    compares = 0;
    rst = 1'b1;
    ld_stb = 1'b0;
    ld_addr = '0;
    ld_word = '0;
    // Flag cases: boundaries first, then random pairs.
    flag_case(1'b0, 8'hFF, 8'h01);
    flag_case(1'b0, 8'h08, 8'h08);
    flag_case(1'b1, 8'h5A, 8'h5A);
    flag_case(1'b1, 8'h01, 8'h00);
    for (int i = 0; i < 4; i++) flag_case(i[0], $random(seed), $random(seed));
    // Twelve file operations, all but clear, move-to-file and the two skips, on a register with carry cleared beforehand.
    for (int i = 0; i < 12; i++) begin
      v = $random(seed);
      w = $random(seed);
      emit(14'h1003);
      movlw(v);
      movwf(7'h30, 2'b00, 1'b1);
      movlw(w);
      emit({2'b00, ops[i], 1'b1, 7'h30});
      exp_q.push_back({9'h030, ref_op(ops[i], v, w)});
    end
    // Indirect store and load through the pointer register.
    v = $random(seed);
    movlw(8'h45);
    movwf(7'h04, 2'b00, 1'b0);
    movlw(v);
    emit(14'h0080);
    exp_q.push_back({9'h045, v});
    movlw(8'h00);
    emit(14'h0800);
    w_exp = v;
    movwf(7'h46, 2'b00, 1'b1);
    // Direct store into the second bank.
    emit(14'h1683);
    movwf(7'h20, 2'b01, 1'b1);
    emit(14'h1283);
    // Decrement to zero skips the next store; a call then returns with a literal.
    movlw(8'h01);
    movwf(7'h31, 2'b00, 1'b1);
    emit({2'b00, 4'hB, 1'b1, 7'h31});
    exp_q.push_back({9'h031, 8'h00});
    movwf(7'h52, 2'b00, 1'b0);
    emit({3'b100, 11'(prog.size() + 3)});
    w_exp = 8'hC3;
    movwf(7'h53, 2'b00, 1'b1);
    emit({3'b101, 11'(prog.size() + 2)});
    emit({6'b110100, 8'hC3});
    // A jump over a store that must never reach the bus, then a parking loop.
    emit({3'b101, 11'(prog.size() + 2)});
    movwf(7'h50, 2'b00, 1'b0);
    movwf(7'h51, 2'b00, 1'b1);
    emit({3'b101, 11'(prog.size())});
    for (int i = 0; i < prog.size(); i++) begin
      ld_addr = PC_W'(i);
      ld_word = prog[i];
      #0.1 ld_stb = 1'b1;
      #0.1 ld_stb = 1'b0;
    end
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 2000 && exp_q.size() != 0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    #1;
    check("pending", 17'(exp_q.size()), 17'h00000);
    check("acc", {9'h000, acc_q}, {9'h000, w_exp});
    finish_test;
  end
endmodule
